//--- rtl/controller_fault_handler.sv
// Holds the fault handler of the controller with its AXI4-Lite registers.
// Assumes fault and event inputs are synchronous to aclk, pins are not.
`timescale 1ns/1ps
// Contract
// - Fatal fault halts scan, forces outputs off.
// - Halt holds until reset or program-mode clear.
// - Power loss darkens all; others light alarm; power loss darkens only from run, not halt, and watchdog F8 lights no alarm.
// - Supply gap 10 ms or 2 ms is fatal.
// - Memory fault gives F1 with six causes.
// - Missing end instruction gives F0.
// - Expansion bus transfer failure gives C0.
// - Too many expansion units gives E1.
// - Scan beyond configured limit gives 9F.
// - Fault code goes into eight status bits.
// - Hardware faults set their cause flags; only the six memory causes are flagged, the other faults set none.
// - Non-fatal alarm flashes, continues, writes number.
// - Non-fatal alarm cleared by 00 or console.
// - Fatal alarm halts, lights alarm, writes number.
// - Log fatal alarm number with clock time.
// - Message instruction sends sixteen characters out.
// - Program writes refused unless protect bits zero.
// - Edit refused unless last word is no-op.
// - Out of range addresses are refused.
// - Fatal alarm number 00 entry refused.
// - Watchdog over 100 ms gives F8, bit 9.
module controller_fault_handler #(
  parameter int ac_loss_limit  = fault_pkg::ac_loss_cycles,
  parameter int dc_loss_limit  = fault_pkg::dc_loss_cycles,
  parameter int watchdog_limit = fault_pkg::watchdog_cycles,
  parameter int prog_top       = 16'h07ff,
  parameter int data_top       = 16'h1fff
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        power_good_pin,
  input  wire logic [5:0]  memory_cause,
  input  wire logic        no_end_instr,
  input  wire logic        expansion_bus_fail,
  input  wire logic        unit_overflow,
  input  wire logic        scan_start,
  input  wire logic        nonfatal_alarm_exec,
  input  wire logic        fatal_alarm_exec,
  input  wire logic [7:0]  alarm_number,
  input  wire logic        rtc_fitted,
  input  wire logic [31:0] rtc_time,
  input  wire logic        console_message_instr,
  input  wire logic [127:0] message_text,
  input  wire logic        last_word_is_nop,
  output logic             run_enable,
  output logic             outputs_enable,
  output logic             power_indicator,
  output logic             run_indicator,
  output logic             alarm_indicator,
  output logic [7:0]       special_status_area,
  output logic [127:0]     message_out,
  output logic             message_valid
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {st_run = 2'b00, st_halt = 2'b01,
                            st_dark = 2'b11} mode_t;
  mode_t       mode, next_mode;
  logic [7:0]  fault_code, next_fault_code;
  logic [5:0]  aux_flags, next_aux_flags;
  logic        nf_active, next_nf_active;
  logic [7:0]  nf_code, next_nf_code;
  logic        scan_over, next_scan_over;
  logic [31:0] control, next_control;
  logic [31:0] config_word, next_config_word;
  logic [31:0] edit_word, next_edit_word;
  logic [2:0]  refusal, next_refusal;
  logic [39:0] alarm_log, next_alarm_log;
  logic [127:0] msg_q, next_msg_q;
  logic        msg_v, next_msg_v;
  logic [31:0] loss_cnt, next_loss_cnt;
  logic [31:0] cyc_cnt, next_cyc_cnt;
  logic [22:0] flash_cnt, next_flash_cnt;
  logic        pg_meta, pg_sync;
  logic        aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [7:0]  aw_q, next_aw_q;
  logic [31:0] w_q, next_w_q;
  logic        bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= fault_pkg::reg_message) && (a[1:0] == 2'h0);
  endfunction : mapped
  logic        fatal_hw, power_lost, cycle_over, wr_go;
  logic [31:0] loss_limit;
  always_comb
  begin
    loss_limit = control[fault_pkg::ctl_dc_power_bit] ?
                 32'(dc_loss_limit) : 32'(ac_loss_limit);
    power_lost = (loss_cnt >= loss_limit);
    // One millisecond comes from the supply limit, so both share a time base.
    cycle_over = (config_word[15:0] != 16'h0000) &&
                 (cyc_cnt >= 32'(config_word[15:0]) *
                  32'(ac_loss_limit / fault_pkg::ac_loss_ms));
    fatal_hw   = (|memory_cause) || no_end_instr || expansion_bus_fail ||
                 unit_overflow || cycle_over;
    wr_go      = aw_hold && w_hold && !bvalid;
  end
  // ****************************************************************
  // Fault logic
  // ****************************************************************
  always_comb
  begin
    next_mode       = mode;
    next_fault_code = fault_code;
    next_aux_flags  = aux_flags | memory_cause;
    next_nf_active  = nf_active;
    next_nf_code    = nf_code;
    next_scan_over  = scan_over;
    next_alarm_log  = alarm_log;
    next_loss_cnt   = pg_sync ? 32'h0 : loss_cnt + 32'h1;
    next_cyc_cnt    = scan_start ? 32'h0 : cyc_cnt + 32'h1;
    next_flash_cnt  = flash_cnt + 23'h1;
    next_msg_q      = msg_q;
    next_msg_v      = 1'b0;
    if (wr_go && aw_q == fault_pkg::reg_control &&
        w_q[fault_pkg::ctl_clear_bit])
    begin
      next_nf_active = 1'b0;
      if (control[fault_pkg::ctl_prog_mode_bit] && mode == st_halt)
      begin
        next_mode      = st_run;
        next_aux_flags = memory_cause;
      end
    end
    if (nonfatal_alarm_exec)
      next_nf_active = (alarm_number != 8'h00);
    if (nonfatal_alarm_exec && alarm_number != 8'h00)
      next_nf_code = alarm_number;
    if (cyc_cnt >= 32'(watchdog_limit))
      next_scan_over = 1'b1;
    if (mode == st_run && power_lost)
      next_mode = st_dark;
    else if (mode == st_run && (fatal_hw || fatal_alarm_exec))
    begin
      next_mode = st_halt;
      if (|memory_cause)
        next_fault_code = fault_pkg::code_memory;
      else if (no_end_instr)
        next_fault_code = fault_pkg::code_no_end;
      else if (expansion_bus_fail)
        next_fault_code = fault_pkg::code_bus;
      else if (unit_overflow)
        next_fault_code = fault_pkg::code_unit_over;
      else if (cycle_over)
        next_fault_code = fault_pkg::code_cycle_over;
      else
      begin
        next_fault_code = alarm_number;
        if (rtc_fitted)
          next_alarm_log = {alarm_number, rtc_time};
      end
    end
    if (console_message_instr && mode == st_run)
    begin
      next_msg_q = message_text;
      next_msg_v = 1'b1;
    end
  end
  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [15:0] ed_addr;
  always_comb
  begin
    ed_addr          = w_q[15:0];
    next_aw_hold     = aw_hold;
    next_w_hold      = w_hold;
    next_aw_q        = aw_q;
    next_w_q         = w_q;
    next_bvalid      = bvalid && !s_axi_bready;
    next_bresp       = bresp;
    next_rvalid      = rvalid && !s_axi_rready;
    next_rresp       = rresp;
    next_rdata       = rdata;
    next_control     = control & ~32'h5;
    next_config_word = config_word;
    next_edit_word   = edit_word;
    next_refusal     = refusal;
    if (s_axi_awvalid && !aw_hold)
    begin
      next_aw_hold = 1'b1;
      next_aw_q    = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold)
    begin
      next_w_hold = 1'b1;
      next_w_q    = s_axi_wdata;
    end
    if (wr_go)
    begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_q) ? fault_pkg::resp_okay :
                     fault_pkg::resp_slverr;
      case (aw_q)
        fault_pkg::reg_control: next_control = w_q;
        fault_pkg::reg_config:  next_config_word = w_q;
        fault_pkg::reg_edit:
        begin
          next_refusal = 3'h0;
          if (config_word[19:16] != 4'h0)
            next_refusal[0] = 1'b1;
          else if (!last_word_is_nop)
            next_refusal[1] = 1'b1;
          else if (w_q[31] ? (ed_addr > 16'(data_top))
                           : (ed_addr > 16'(prog_top)))
            next_refusal[2] = 1'b1;
          else if (w_q[30] && w_q[23:16] == 8'h00)
            next_refusal[2] = 1'b1;
          else
            next_edit_word = w_q;
        end
        default: next_edit_word = edit_word;
      endcase
    end
    if (s_axi_arvalid && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(s_axi_araddr) ? fault_pkg::resp_okay :
                    fault_pkg::resp_slverr;
      case (s_axi_araddr)
        fault_pkg::reg_status:
          next_rdata = {22'h0, scan_over, nf_active, special_status_area};
        fault_pkg::reg_cause:   next_rdata = {26'h0, aux_flags};
        fault_pkg::reg_control: next_rdata = control;
        fault_pkg::reg_config:  next_rdata = config_word;
        fault_pkg::reg_edit:    next_rdata = edit_word;
        fault_pkg::reg_refusal: next_rdata = {29'h0, refusal};
        fault_pkg::reg_alarm_log: next_rdata = alarm_log[31:0];
        fault_pkg::reg_message: next_rdata = {24'h0, alarm_log[39:32]};
        default: next_rdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge aclk)
  begin
    pg_meta <= power_good_pin;
    pg_sync <= pg_meta;
    if (!aresetn)
    begin
      mode <= st_run; fault_code <= 8'h0; aux_flags <= 6'h0;
      nf_active <= 1'b0; nf_code <= 8'h0; scan_over <= 1'b0;
      control <= 32'h0; config_word <= fault_pkg::config_reset;
      edit_word <= 32'h0; refusal <= 3'h0; alarm_log <= 40'h0;
      msg_q <= 128'h0; msg_v <= 1'b0; loss_cnt <= 32'h0;
      cyc_cnt <= 32'h0; flash_cnt <= 23'h0; aw_hold <= 1'b0;
      w_hold <= 1'b0; aw_q <= 8'h0; w_q <= 32'h0; bvalid <= 1'b0;
      bresp <= 2'h0; rvalid <= 1'b0; rresp <= 2'h0; rdata <= 32'h0;
    end
    else
    begin
      mode <= next_mode; fault_code <= next_fault_code;
      aux_flags <= next_aux_flags; nf_active <= next_nf_active;
      nf_code <= next_nf_code; scan_over <= next_scan_over;
      control <= next_control; config_word <= next_config_word;
      edit_word <= next_edit_word; refusal <= next_refusal;
      alarm_log <= next_alarm_log; msg_q <= next_msg_q;
      msg_v <= next_msg_v; loss_cnt <= next_loss_cnt;
      cyc_cnt <= next_cyc_cnt; flash_cnt <= next_flash_cnt;
      aw_hold <= next_aw_hold; w_hold <= next_w_hold; aw_q <= next_aw_q;
      w_q <= next_w_q; bvalid <= next_bvalid; bresp <= next_bresp;
      rvalid <= next_rvalid; rresp <= next_rresp; rdata <= next_rdata;
    end
  end
  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb
  begin
    run_enable      = (mode == st_run);
    outputs_enable  = (mode == st_run);
    power_indicator = (mode != st_dark);
    run_indicator   = (mode == st_run);
    alarm_indicator = (mode == st_halt) ||
                      (mode == st_run && nf_active && flash_cnt[22]);
    if (mode != st_run)
      special_status_area = fault_code;
    else if (nf_active)
      special_status_area = nf_code;
    else if (scan_over)
      special_status_area = fault_pkg::code_scan_over;
    else
      special_status_area = fault_pkg::code_none;
    message_out   = msg_q;
    message_valid = msg_v;
    s_axi_awready = !aw_hold;
    s_axi_wready  = !w_hold;
    s_axi_bvalid  = bvalid;
    s_axi_bresp   = bresp;
    s_axi_arready = !rvalid;
    s_axi_rvalid  = rvalid;
    s_axi_rresp   = rresp;
    s_axi_rdata   = rdata;
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_halt_off;
    @(posedge aclk) disable iff (!aresetn)
      (mode == st_run && !power_lost && fatal_alarm_exec) |=>
        (!outputs_enable && !run_enable);
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("no halt");
  property p_stay;
    @(posedge aclk) disable iff (!aresetn)
      (mode == st_halt && !(wr_go && aw_q == fault_pkg::reg_control &&
       w_q[fault_pkg::ctl_clear_bit])) |=> (mode == st_halt);
  endproperty
  a_stay: assert property (p_stay) else $error("left halt");
  property p_dark;
    @(posedge aclk) disable iff (!aresetn)
      (mode == st_dark) |-> (!power_indicator && !alarm_indicator);
  endproperty
  a_dark: assert property (p_dark) else $error("not dark");
  property p_loss;
    @(posedge aclk) disable iff (!aresetn)
      (mode == st_run && power_lost) |=> (mode == st_dark);
  endproperty
  a_loss: assert property (p_loss) else $error("loss missed");
  property p_mem;
    @(posedge aclk) disable iff (!aresetn)
      (mode == st_run && !power_lost && |memory_cause) |=>
        (special_status_area == fault_pkg::code_memory);
  endproperty
  a_mem: assert property (p_mem) else $error("bad F1");
  property p_noend;
    @(posedge aclk) disable iff (!aresetn)
      (mode == st_run && !power_lost && !(|memory_cause) && no_end_instr)
        |=> (special_status_area == fault_pkg::code_no_end);
  endproperty
  a_noend: assert property (p_noend) else $error("bad F0");
  property p_nf;
    @(posedge aclk) disable iff (!aresetn)
      (mode == st_run && !fatal_hw && !fatal_alarm_exec && !power_lost &&
       nonfatal_alarm_exec && alarm_number != 8'h00) |=>
        (run_enable && special_status_area == $past(alarm_number));
  endproperty
  a_nf: assert property (p_nf) else $error("bad alarm");
  property p_prot;
    @(posedge aclk) disable iff (!aresetn)
      (wr_go && aw_q == fault_pkg::reg_edit &&
       config_word[19:16] != 4'h0) |=> refusal[0];
  endproperty
  a_prot: assert property (p_prot) else $error("no protect");
endmodule : controller_fault_handler

//--- inc/fault_pkg.sv
// Holds constants shared by the fault handler: codes, offsets and timing.
// Assumes a 200 MHz scan clock and an AXI4-Lite register bus.
package fault_pkg;
  // ****************************************************************
  // Fault codes
  // ****************************************************************
  localparam logic [7:0] code_none        = 8'h00;
  localparam logic [7:0] code_memory      = 8'hf1;
  localparam logic [7:0] code_no_end      = 8'hf0;
  localparam logic [7:0] code_bus         = 8'hc0;
  localparam logic [7:0] code_unit_over   = 8'he1;
  localparam logic [7:0] code_cycle_over  = 8'h9f;
  localparam logic [7:0] code_scan_over   = 8'hf8;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int clk_mhz            = 200;
  localparam int ac_loss_ms         = 10;
  localparam int dc_loss_ms         = 2;
  localparam int watchdog_ms        = 100;
  localparam int ac_loss_cycles     = ac_loss_ms * clk_mhz * 1000;
  localparam int dc_loss_cycles     = dc_loss_ms * clk_mhz * 1000;
  localparam int watchdog_cycles    = watchdog_ms * clk_mhz * 1000;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] reg_status    = 8'h00;
  localparam logic [7:0] reg_cause     = 8'h04;
  localparam logic [7:0] reg_control   = 8'h08;
  localparam logic [7:0] reg_config    = 8'h0c;
  localparam logic [7:0] reg_edit      = 8'h10;
  localparam logic [7:0] reg_refusal   = 8'h14;
  localparam logic [7:0] reg_alarm_log = 8'h18;
  localparam logic [7:0] reg_message   = 8'h1c;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int ctl_clear_bit      = 0;
  localparam int ctl_prog_mode_bit  = 1;
  localparam int ctl_edit_go_bit    = 2;
  localparam int ctl_dc_power_bit   = 3;
  localparam int status_scan_bit    = 9;
  localparam logic [31:0] config_reset = 32'h0000_0000;
  localparam logic [1:0]  resp_okay    = 2'h0;
  localparam logic [1:0]  resp_slverr  = 2'h2;
  localparam int cause_width        = 6;
endpackage : fault_pkg

//--- verification/console_model.sv
// Console model: AXI4-Lite master tasks driving the fault handler.
// Assumes one clock, with the slave answering on bvalid and rvalid.
`timescale 1ns/1ps
module console_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial
  begin
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
  end

  // Writes one word and waits for its response.
  task automatic write_word(input logic [7:0] a, input logic [31:0] d,
                            output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : write_word

  // Reads one word and waits for its data.
  task automatic read_word(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : read_word

  // Enters the given mode, clears twice, then returns to run.
  task automatic clear_fault(input logic [31:0] mode);
    logic [1:0] r;
    write_word(fault_pkg::reg_control, mode, r);
    write_word(fault_pkg::reg_control, mode | 32'h1, r);
    write_word(fault_pkg::reg_control, mode | 32'h1, r);
    write_word(fault_pkg::reg_control, 32'h0, r);
  endtask : clear_fault
endmodule : console_model

//--- verification/test_controller_fault_handler.sv
// Self-checking bench for the fault handler with a console model.
// Assumes short loss and watchdog limits set through parameters.
`timescale 1ns/1ps
module test_controller_fault_handler;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic [7:0]   awaddr, araddr, alarm_number = 8'h00, code;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, note_valid;
  logic [31:0]  wdata, rdata, v, rtc_time = 32'h0;
  logic [1:0]   bresp, rresp, r;
  logic [8:0]   hw_fault = 9'h000;
  logic         power_good = 1'b1, scan_start = 1'b0, scan_run = 1'b1;
  logic         nf_exec = 1'b0, f_exec = 1'b0, rtc_fitted = 1'b0;
  logic         note_instr = 1'b0, last_nop = 1'b1;
  logic [127:0] note_text = 128'h0, note_out;
  logic [3:0]   wstrb;
  logic         run_enable, outputs_enable, pwr_ind, run_ind, alm_ind;
  int           fail_count = 0;
  int           checks_done = 0;
  int           n;

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) scan_start <= scan_run && !scan_start;

  controller_fault_handler #(.ac_loss_limit(50), .dc_loss_limit(20),
    .watchdog_limit(50)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .power_good_pin(power_good),
    .memory_cause(hw_fault[5:0]), .no_end_instr(hw_fault[6]),
    .expansion_bus_fail(hw_fault[7]), .unit_overflow(hw_fault[8]),
    .scan_start(scan_start), .nonfatal_alarm_exec(nf_exec),
    .fatal_alarm_exec(f_exec), .alarm_number(alarm_number),
    .rtc_fitted(rtc_fitted), .rtc_time(rtc_time),
    .console_message_instr(note_instr), .message_text(note_text),
    .last_word_is_nop(last_nop), .run_enable(run_enable),
    .outputs_enable(outputs_enable), .power_indicator(pwr_ind),
    .run_indicator(run_ind), .alarm_indicator(alm_ind),
    .special_status_area(code), .message_out(note_out),
    .message_valid(note_valid));

  console_model u_con (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask : check

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  q;
    u_con.read_word(a, d, q);
    check(d & m, e);
  endtask : rd

  task automatic outs(input logic [4:0] e);
    check({run_enable, outputs_enable, pwr_ind, run_ind, alm_ind}, e);
  endtask : outs

  task automatic cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask : cyc

  task automatic do_reset;
    aresetn <= 1'b0;
    cyc(6);
    aresetn <= 1'b1;
    cyc(1);
  endtask : do_reset

  task automatic pulse_alarm(input logic fatal, input logic [7:0] num);
    alarm_number <= num;
    f_exec <= fatal;
    nf_exec <= !fatal;
    cyc(1);
    f_exec <= 1'b0;
    nf_exec <= 1'b0;
    cyc(3);
  endtask : pulse_alarm

  task automatic edit(input logic [31:0] e);
    u_con.write_word(fault_pkg::reg_edit, e, r);
    u_con.write_word(fault_pkg::reg_control, 32'h6, r);
    u_con.write_word(fault_pkg::reg_control, 32'h0, r);
  endtask : edit

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    cyc(20000);
    fail_count++;
    summarize();
  end

  initial
  begin
    do_reset();
    outs(5'h1e);
    for (int i = 0; i < 9; i++)
    begin
      hw_fault <= 9'h001 << i;
      cyc(4);
      check(code, i < 6 ? 8'hf1 : i == 6 ? 8'hf0 : i == 7 ? 8'hc0 : 8'he1);
      outs(5'h05);
      rd(fault_pkg::reg_cause, 32'h3f, i < 6 ? 32'h1 << i : 32'h0);
      hw_fault <= 9'h000;
      cyc(4);
      outs(5'h05);
      u_con.clear_fault(32'h2);
      check(code, 8'h00);
      outs(5'h1e);
    end
    hw_fault <= 9'h1c1;
    cyc(4);
    check(code, 8'hf1);
    hw_fault <= 9'h000;
    u_con.clear_fault(32'h2);
    $display("test hardware faults done");
    pulse_alarm(1'b0, 8'h17);
    check(code, 8'h17);
    check(run_enable, 1'b1);
    rd(fault_pkg::reg_status, 32'h1ff, 32'h117);
    pulse_alarm(1'b0, 8'h00);
    check(code, 8'h00);
    pulse_alarm(1'b0, 8'h23);
    u_con.clear_fault(32'h0);
    check(code, 8'h00);
    pulse_alarm(1'b0, 8'h23);
    rtc_fitted <= 1'b1;
    rtc_time <= 32'h0012_3456;
    pulse_alarm(1'b1, 8'h42);
    check(code, 8'h42);
    outs(5'h05);
    rd(fault_pkg::reg_alarm_log, 32'hffff_ffff, 32'h0012_3456);
    rd(fault_pkg::reg_message, 32'hff, 32'h42);
    u_con.clear_fault(32'h2);
    check(code, 8'h00);
    $display("test user alarms done");
    note_text <= "fault handler ok";
    note_instr <= 1'b1;
    cyc(1);
    note_instr <= 1'b0;
    for (n = 0; n < 10 && note_valid !== 1'b1; n++) cyc(1);
    check(note_valid, 1'b1);
    check(note_out, "fault handler ok");
    u_con.write_word(fault_pkg::reg_config, 32'h0001_0000, r);
    edit(32'h0000_0010);
    rd(fault_pkg::reg_refusal, 32'h1, 32'h1);
    u_con.write_word(fault_pkg::reg_config, 32'h0, r);
    last_nop <= 1'b0;
    edit(32'h0000_0010);
    rd(fault_pkg::reg_refusal, 32'h2, 32'h2);
    last_nop <= 1'b1;
    edit(32'h0000_0800);
    rd(fault_pkg::reg_refusal, 32'h4, 32'h4);
    edit(32'h8000_2000);
    rd(fault_pkg::reg_refusal, 32'h4, 32'h4);
    edit(32'h4000_0000);
    rd(fault_pkg::reg_refusal, 32'h4, 32'h4);
    edit(32'h0001_0010);
    rd(fault_pkg::reg_refusal, 32'h7, 32'h0);
    rd(fault_pkg::reg_edit, 32'hffff_ffff, 32'h0001_0010);
    u_con.read_word(8'h40, v, r);
    check(r, fault_pkg::resp_slverr);
    check(v, 32'h0);
    u_con.write_word(8'h42, 32'h1, r);
    check(r, fault_pkg::resp_slverr);
    $display("test console done");
    u_con.write_word(fault_pkg::reg_config, 32'h0000_0008, r);
    scan_run <= 1'b0;
    cyc(45);
    check(code, 8'h9f);
    outs(5'h05);
    scan_run <= 1'b1;
    u_con.write_word(fault_pkg::reg_config, 32'h0, r);
    u_con.clear_fault(32'h2);
    check(code, 8'h00);
    scan_run <= 1'b0;
    cyc(60);
    check(code, 8'hf8);
    check(run_enable, 1'b1);
    rd(fault_pkg::reg_status, 32'h200, 32'h200);
    scan_run <= 1'b1;
    do_reset();
    power_good <= 1'b0;
    cyc(30);
    outs(5'h1e);
    power_good <= 1'b1;
    cyc(4);
    power_good <= 1'b0;
    cyc(60);
    outs(5'h00);
    power_good <= 1'b1;
    do_reset();
    outs(5'h1e);
    u_con.write_word(fault_pkg::reg_control, 32'h8, r);
    power_good <= 1'b0;
    cyc(30);
    outs(5'h00);
    power_good <= 1'b1;
    do_reset();
    $display("test power and watchdog done");
    summarize();
  end
endmodule : test_controller_fault_handler
